// >>> core/sram_ctl_pkg.sv
// constants for the asynchronous static memory controller
package sram_ctl_pkg;
	localparam int ADDR_W     = 16;
	localparam int DATA_W     = 4;
	localparam int CLK_NS     = 20;
	// fastest grade figures in ns
	localparam int T_WP_NS    = 12;
	localparam int T_WP_GH_NS = 10;
	localparam int T_AW_NS    = 12;
	localparam int T_DW_NS    = 7;
	localparam int T_OE_NS    = 8;
	localparam int T_ACC_NS   = 15;
	localparam int T_WZ_NS    = 7;
	localparam int T_CHZ_NS   = 8;
	localparam int T_OH_NS    = 4;
	localparam int T_RC_NS    = 15;
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int WP_CYC  = ns_to_cyc(T_WP_NS);
	localparam int ACC_CYC = ns_to_cyc((T_ACC_NS > T_OE_NS) ? T_ACC_NS : T_OE_NS);
	localparam int HZ_CYC  = ns_to_cyc((T_CHZ_NS > T_WZ_NS) ? T_CHZ_NS : T_WZ_NS);
	localparam int CNT_W   = 4;
	localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_RD, ST_WR, ST_REC} ctl_state_t;
endpackage

// >>> core/sram_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sram_sync2 #(
	parameter int W = 4
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;
	always_comb begin
		meta_nxt = d_i;
		q_nxt    = meta_r;
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_o    <= q_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> core/sram_ctl.sv
// host-side controller driving a 64k x 4 asynchronous static memory
// Summary of operation
// - write happens only while select and write strobe overlap low; captured at end.
// - write strobe stays high throughout every read cycle.
// - address valid before the select falls.
// - cycle lasts from address valid until the next address change.
// - output enable high during writes allows the shorter write pulse.
// - address held valid at least 12 ns before write ends.
// - write data driven at least 7 ns before write ends.
`timescale 1ns/100ps
`default_nettype none
module sram_ctl (
	input  wire logic                           sys_clk_i,
	input  wire logic                           rst_i,
	input  wire logic                           req_i,
	input  wire logic                           we_i,
	input  wire logic [sram_ctl_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [sram_ctl_pkg::DATA_W-1:0] wdata_i,
	output var  logic                           busy_o,
	output var  logic                           rvalid_o,
	output var  logic [sram_ctl_pkg::DATA_W-1:0] rdata_o,
	output var  logic [sram_ctl_pkg::ADDR_W-1:0] word_select_lines_o,
	output var  logic                           cs_n_o,
	output var  logic                           cs_high_o,
	output var  logic                           oe_n_o,
	output var  logic                           we_n_o,
	input  wire logic [sram_ctl_pkg::DATA_W-1:0] bidir_nibble_i,
	output var  logic [sram_ctl_pkg::DATA_W-1:0] bidir_nibble_o,
	output var  logic                           bidir_nibble_oe_o
);
	import sram_ctl_pkg::*;

	ctl_state_t        st_r, st_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic              wr_r, wr_nxt;
	logic [DATA_W-1:0] rd_sync;
	logic              busy_nxt, rvalid_nxt, cs_n_nxt, oe_n_nxt, we_n_nxt, doe_nxt;
	logic [DATA_W-1:0] rdata_nxt, dout_nxt;
	logic [ADDR_W-1:0] addr_nxt;

	// pin data is asynchronous to us, so it is synchronised; costs two cycles of latency
	sram_sync2 #(.W(DATA_W)) u_rd_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.d_i       (bidir_nibble_i),
		.q_o       (rd_sync)
	);

	always_comb begin
		st_nxt     = st_r;
		cnt_nxt    = cnt_r;
		wr_nxt     = wr_r;
		busy_nxt   = busy_o;
		rvalid_nxt = 1'b0;
		rdata_nxt  = rdata_o;
		addr_nxt   = word_select_lines_o;
		dout_nxt   = bidir_nibble_o;
		cs_n_nxt   = cs_n_o;
		oe_n_nxt   = oe_n_o;
		we_n_nxt   = we_n_o;
		doe_nxt    = bidir_nibble_oe_o;
		unique case (st_r)
			ST_IDLE: begin
				if (req_i) begin
					// address goes out one cycle before any strobe
					addr_nxt = addr_i;
					dout_nxt = wdata_i;
					wr_nxt   = we_i;
					busy_nxt = 1'b1;
					st_nxt   = ST_SETUP;
				end
			end
			ST_SETUP: begin
				cs_n_nxt = 1'b0;
				cnt_nxt  = CNT_RST;
				if (wr_r) begin
					// select and strobe fall together, oe stays high
					we_n_nxt = 1'b0;
					doe_nxt  = 1'b1;
					st_nxt   = ST_WR;
				end else begin
					oe_n_nxt = 1'b0;
					we_n_nxt = 1'b1;
					st_nxt   = ST_RD;
				end
			end
			ST_RD: begin
				cnt_nxt = cnt_r + 1'b1;
				// access time plus synchroniser depth before the sample is trusted
				if (cnt_r == CNT_W'(ACC_CYC + 2)) begin
					rdata_nxt  = rd_sync;
					rvalid_nxt = 1'b1;
					cs_n_nxt   = 1'b1;
					oe_n_nxt   = 1'b1;
					cnt_nxt    = CNT_RST;
					st_nxt     = ST_REC;
				end
			end
			ST_WR: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == CNT_W'(WP_CYC - 1)) begin
					// select and strobe rise together; data held one more cycle
					we_n_nxt = 1'b1;
					cs_n_nxt = 1'b1;
					cnt_nxt  = CNT_RST;
					st_nxt   = ST_REC;
				end
			end
			ST_REC: begin
				doe_nxt = 1'b0;
				cnt_nxt = cnt_r + 1'b1;
				// give the memory time to float before the next cycle turns the bus
				if (cnt_r == CNT_W'(HZ_CYC - 1)) begin
					busy_nxt = 1'b0;
					st_nxt   = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r                <= ST_IDLE;
			cnt_r               <= CNT_RST;
			wr_r                <= 1'b0;
			busy_o              <= 1'b0;
			rvalid_o            <= 1'b0;
			rdata_o             <= '0;
			word_select_lines_o <= '0;
			bidir_nibble_o      <= '0;
			cs_n_o              <= 1'b1;
			cs_high_o           <= 1'b0;
			oe_n_o              <= 1'b1;
			we_n_o              <= 1'b1;
			bidir_nibble_oe_o   <= 1'b0;
		end else begin
			st_r                <= st_nxt;
			cnt_r               <= cnt_nxt;
			wr_r                <= wr_nxt;
			busy_o              <= busy_nxt;
			rvalid_o            <= rvalid_nxt;
			rdata_o             <= rdata_nxt;
			word_select_lines_o <= addr_nxt;
			bidir_nibble_o      <= dout_nxt;
			cs_n_o              <= cs_n_nxt;
			cs_high_o           <= ~cs_n_nxt;
			oe_n_o              <= oe_n_nxt;
			we_n_o              <= we_n_nxt;
			bidir_nibble_oe_o   <= doe_nxt;
		end
	end

	property p_wr_only_sel;
		@(posedge sys_clk_i) disable iff (rst_i) !we_n_o |-> !cs_n_o;
	endproperty
	a_wr_only_sel: assert property (p_wr_only_sel) else $error("write strobe without select");
	property p_rd_we_high;
		@(posedge sys_clk_i) disable iff (rst_i) !oe_n_o |-> we_n_o;
	endproperty
	a_rd_we_high: assert property (p_rd_we_high) else $error("strobe low in read");
	property p_cs_pair;
		@(posedge sys_clk_i) disable iff (rst_i) cs_high_o == !cs_n_o;
	endproperty
	a_cs_pair: assert property (p_cs_pair) else $error("selects disagree");
	property p_oe_wr;
		@(posedge sys_clk_i) disable iff (rst_i) $fell(we_n_o) |-> oe_n_o [*2];
	endproperty
	a_oe_wr: assert property (p_oe_wr) else $error("oe low in write");
	property p_cs_fall;
		@(posedge sys_clk_i) disable iff (rst_i) $fell(we_n_o) |-> $fell(cs_n_o);
	endproperty
	a_cs_fall: assert property (p_cs_fall) else $error("select fell late");
	property p_cs_rise;
		@(posedge sys_clk_i) disable iff (rst_i) $rose(we_n_o) |-> $rose(cs_n_o) && bidir_nibble_oe_o;
	endproperty
	a_cs_rise: assert property (p_cs_rise) else $error("select not rising with strobe");
	property p_addr_stable;
		@(posedge sys_clk_i) disable iff (rst_i) !cs_n_o |-> $stable(word_select_lines_o);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected");
	// address must have stood since before the strobe fell, a full cycle ahead of write end
	property p_wr_addr;
		@(posedge sys_clk_i) disable iff (rst_i) $rose(we_n_o) |-> word_select_lines_o == $past(word_select_lines_o, 2);
	endproperty
	a_wr_addr: assert property (p_wr_addr) else $error("address moved during write");
	property p_rd_done;
		@(posedge sys_clk_i) disable iff (rst_i) $fell(oe_n_o) |-> ##[1:8] rvalid_o;
	endproperty
	a_rd_done: assert property (p_rd_done) else $error("read never completed");
	c_read:  cover property (@(posedge sys_clk_i) rvalid_o);
	c_write: cover property (@(posedge sys_clk_i) $rose(we_n_o));
	c_b2b:   cover property (@(posedge sys_clk_i) $fell(busy_o) && req_i);
endmodule
`default_nettype wire

// >>> verification/sram_model.sv
// behavioural model of the 64k x 4 asynchronous static memory
`timescale 1ns/100ps
`default_nettype none
module sram_model
	import sram_ctl_pkg::*;
#(
	parameter int ACC_NS = 8
) (
	input  wire logic [ADDR_W-1:0] a_i,
	input  wire logic              cs_n_i,
	input  wire logic              cs_high_i,
	input  wire logic              oe_n_i,
	input  wire logic              we_n_i,
	input  wire logic [DATA_W-1:0] host_d_i,
	input  wire logic              host_oe_i,
	output wire logic [DATA_W-1:0] pin_o
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] last_r = 4'h0;
	logic [DATA_W-1:0] pin_c;
	logic              sel;
	logic              wr;
	logic              drv;
	assign sel = !cs_n_i && cs_high_i;
	assign wr  = sel && !we_n_i;
	assign drv = sel && !oe_n_i && we_n_i;
	// stored at the end of the overlap, not at its start
	always @(negedge wr) mem[a_i] = host_d_i;
	// a floating pin shows the inverse of its last level, not a kind guess
	always @* begin
		if (host_oe_i) begin
			last_r = host_d_i;
			pin_c  = host_d_i;
		end else if (drv) begin
			last_r = mem[a_i];
			pin_c  = mem[a_i];
		end else begin
			pin_c = ~last_r;
		end
	end
	// slowest legal answer of the fastest grade
	assign #(ACC_NS) pin_o = pin_c;
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the static memory controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import sram_ctl_pkg::*;
	logic              clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0;
	logic [ADDR_W-1:0] addr = 16'h0000, a_pin, a_prev = 16'h0000, cur_a = 16'h0000;
	logic              cur_w = 1'b0;
	logic [DATA_W-1:0] wd = 4'h0, cur_wd = 4'h0, rd, pin, nib_o;
	logic              busy, rv, cs_n, cs_hi, oe_n, we_n, nib_oe, cs_prev = 1'b1;
	int                n_mismatch = 0, compares = 0, cyc = 0;
	sram_ctl DUT (.sys_clk_i(clk), .rst_i(rst), .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wd),
		.busy_o(busy), .rvalid_o(rv), .rdata_o(rd), .word_select_lines_o(a_pin), .cs_n_o(cs_n),
		.cs_high_o(cs_hi), .oe_n_o(oe_n), .we_n_o(we_n), .bidir_nibble_i(pin), .bidir_nibble_o(nib_o),
		.bidir_nibble_oe_o(nib_oe));
	sram_model #(.ACC_NS(T_ACC_NS)) mem_u (.a_i(a_pin), .cs_n_i(cs_n), .cs_high_i(cs_hi), .oe_n_i(oe_n),
		.we_n_i(we_n), .host_d_i(nib_o), .host_oe_i(nib_oe), .pin_o(pin));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_nib(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// pin relations judged mid-cycle, where every register has settled
	always @(negedge clk) begin
		if (!rst) begin
			chk_bit(cs_hi, !cs_n);
			if (!we_n) chk_bit(oe_n, 1'b1);
			if (!we_n) chk_bit(cs_n, 1'b0);
			if (!we_n) chk_nib(nib_o, cur_wd);
			if (!oe_n) chk_bit(we_n, 1'b1);
			if (!cs_n && !cs_prev) chk_nib(a_pin, a_prev);
			if (!cs_n) chk_nib(a_pin, cur_a);
			if (!cs_n && cur_w) chk_bit(we_n, 1'b0);
			if (!cs_n && !cur_w) chk_bit(oe_n, 1'b0);
			if (!we_n) chk_bit(nib_oe, 1'b1);
			if (!oe_n) chk_bit(nib_oe, 1'b0);
		end
		cs_prev = cs_n;
		a_prev = a_pin;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20) begin
			@(posedge clk);
			#2;
			n++;
		end
		chk_bit(busy, 1'b0);
	endtask
	task automatic request(input logic w, input logic [15:0] a, input logic [3:0] d);
		wait_idle();
		req = 1'b1;
		we = w;
		addr = a;
		wd = d;
		if (w) cur_wd = d;
		cur_a = a;
		cur_w = w;
		@(posedge clk);
		#2;
		req = 1'b0;
		@(posedge clk);
		#2;
	endtask
	task automatic do_read(input logic [15:0] a, input logic [3:0] exp);
		int n;
		request(1'b0, a, 4'h0);
		n = 0;
		while (rv !== 1'b1 && n < 20) begin
			@(posedge clk);
			#2;
			n++;
		end
		chk_bit(rv, 1'b1);
		chk_nib(rd, exp);
	endtask
	task automatic t_idle();
		chk_bit(cs_n, 1'b1);
		chk_bit(cs_hi, 1'b0);
		chk_bit(we_n, 1'b1);
		chk_bit(nib_oe, 1'b0);
	endtask
	task automatic t_boundary();
		request(1'b1, 16'h0000, 4'hA);
		request(1'b1, 16'hFFFF, 4'h5);
		request(1'b1, 16'h1234, 4'hF);
		do_read(16'h0000, 4'hA);
		do_read(16'hFFFF, 4'h5);
		do_read(16'h1234, 4'hF);
		request(1'b1, 16'h1234, 4'h3);
		do_read(16'h1234, 4'h3);
	endtask
	// a request while busy is dropped, so the first value must survive
	task automatic t_refuse();
		request(1'b1, 16'h00A5, 4'h6);
		chk_bit(busy, 1'b1);
		req = 1'b1;
		addr = 16'h00A5;
		wd = 4'h9;
		@(posedge clk);
		#2;
		req = 1'b0;
		do_read(16'h00A5, 4'h6);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#2;
		rst = 1'b0;
		t_idle();
		t_boundary();
		t_refuse();
		wait_idle();
		t_idle();
		report_and_stop();
	end
endmodule
`default_nettype wire
